// ---- core/byte_queue.sv ----
// small first-in first-out buffer with valid/ready on both sides
// assumes a synchronous active-high reset and one clock
`timescale 1ns/10ps
module byte_queue #(
	parameter int unsigned WIDTH = 8,
	parameter int unsigned DEPTH = 4
) (
	input wire logic mclk,
	input wire logic reset,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int unsigned PTR_W = $clog2(DEPTH);
	localparam int unsigned CNT_W = $clog2(DEPTH + 1);
	localparam logic [CNT_W-1:0] FULL_COUNT = CNT_W'(DEPTH);
	localparam logic [PTR_W-1:0] LAST_PTR = PTR_W'(DEPTH - 1);

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [PTR_W-1:0] wr_ptr_q;
	logic [PTR_W-1:0] rd_ptr_q;
	logic [CNT_W-1:0] count_q;
	logic push;
	logic pop;

	assign in_ready = (count_q != FULL_COUNT);
	assign out_valid = (count_q != '0);
	assign out_data = mem_q[rd_ptr_q];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	always_ff @(posedge mclk) begin
		if (push) begin
			mem_q[wr_ptr_q] <= in_data;
		end
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			wr_ptr_q <= '0;
			rd_ptr_q <= '0;
		end else begin
			if (push) begin
				wr_ptr_q <= (wr_ptr_q == LAST_PTR) ? '0 : wr_ptr_q + 1'b1;
			end
			if (pop) begin
				rd_ptr_q <= (rd_ptr_q == LAST_PTR) ? '0 : rd_ptr_q + 1'b1;
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			count_q <= '0;
		end else if (push && !pop) begin
			count_q <= count_q + 1'b1;
		end else if (pop && !push) begin
			count_q <= count_q - 1'b1;
		end
	end
endmodule

// ---- core/configurable_logic_cell.sv ----
// one configurable logic cell: two sum-of-products arrays and an 8-bit datapath
// assumes byte bus requests synchronous to mclk, one request per cycle at most
`timescale 1ns/10ps
module configurable_logic_cell (
	input wire logic mclk,
	input wire logic reset,
	input wire logic_cell_pkg::bus_req_s bus_req,
	output logic [7:0] bus_rdata_q,
	output logic bus_rvalid_q,
	input wire logic [logic_cell_pkg::PLD_COUNT-1:0][logic_cell_pkg::PLD_IN-1:0] pld_in,
	input wire logic_cell_pkg::pld_cfg_s [logic_cell_pkg::PLD_COUNT-1:0] pld_cfg,
	output logic [logic_cell_pkg::PLD_COUNT-1:0][logic_cell_pkg::PLD_OUTS-1:0] pld_out,
	input wire logic [logic_cell_pkg::CFG_IDX_W-1:0] cfg_sel,
	output logic [logic_cell_pkg::COND_W-1:0] cond_q,
	input wire logic [logic_cell_pkg::STATUS_IN_W-1:0] status_in,
	output logic [7:0] ctrl_q
);
	logic cell_rst;
	logic dp_run;
	logic pld_run;
	logic [7:0] acc0_q;
	logic [7:0] acc1_q;
	logic [7:0] data0_q;
	logic [7:0] data1_q;
	logic [7:0] mask0_q;
	logic [7:0] mask1_q;
	logic [2:0] cfg_index_q;
	logic [7:0] cfg_low_q;
	logic [15:0] cfg_mem_q [logic_cell_pkg::CFG_WORDS];
	logic q0_overflow_q;
	logic q1_underflow_q;
	logic_cell_pkg::dp_cfg_s cfg;
	logic [7:0] src_a;
	logic [7:0] src_b;
	logic [8:0] alu_wide;
	logic [7:0] alu_res;
	logic [7:0] shifted;
	logic stall;
	logic step;
	logic wr_hit;
	logic rd_hit;
	logic q0_in_ready;
	logic q0_out_valid;
	logic [7:0] q0_out_data;
	logic q1_in_ready;
	logic q1_out_valid;
	logic [7:0] q1_out_data;
	logic [7:0] q1_push_data;
	logic [7:0] load_byte;
	logic [7:0] read_mux;
	logic [7:0] status_byte;

	// local reset and run gating
	assign cell_rst = reset || ctrl_q[logic_cell_pkg::CTRL_SOFT_RESET];
	assign dp_run = ctrl_q[logic_cell_pkg::CTRL_DP_RUN];
	assign pld_run = ctrl_q[logic_cell_pkg::CTRL_PLD_RUN];

	// two arrays, each output may share any of the eight terms
	for (genvar p = 0; p < logic_cell_pkg::PLD_COUNT; p++) begin : g_pld
		logic [logic_cell_pkg::PLD_TERMS-1:0] terms;
		logic [logic_cell_pkg::PLD_OUTS-1:0] sums;
		logic [logic_cell_pkg::PLD_OUTS-1:0] sum_q;
		for (genvar t = 0; t < logic_cell_pkg::PLD_TERMS; t++) begin : g_term
			// unused inputs force a one into the AND
			assign terms[t] = &(~pld_cfg[p].term[t].use_in |
				(pld_in[p] ^ pld_cfg[p].term[t].invert));
		end
		for (genvar o = 0; o < logic_cell_pkg::PLD_OUTS; o++) begin : g_out
			assign sums[o] = |(terms & pld_cfg[p].or_sel[o]);
			assign pld_out[p][o] = pld_cfg[p].reg_sel[o] ? sum_q[o] : sums[o];
		end
		always_ff @(posedge mclk) begin
			if (cell_rst) begin
				sum_q <= '0;
			end else if (pld_run) begin
				sum_q <= sums;
			end
		end
		a_pld_registered: assert property (@(posedge mclk) disable iff (reset)
			pld_run && !cell_rst |=> sum_q == $past(sums))
			else $error("registered array output did not follow its sum");
	end

	// operation chosen cycle by cycle from routed address
	assign cfg = logic_cell_pkg::dp_cfg_s'(cfg_mem_q[cfg_sel]);

	function automatic logic [7:0] pick(input logic_cell_pkg::src_sel_e s,
		input logic [7:0] a0, input logic [7:0] a1, input logic [7:0] d0, input logic [7:0] d1);
		unique case (s)
			logic_cell_pkg::SRC_ACC0: pick = a0;
			logic_cell_pkg::SRC_ACC1: pick = a1;
			logic_cell_pkg::SRC_DATA0: pick = d0;
			logic_cell_pkg::SRC_DATA1: pick = d1;
		endcase
	endfunction

	assign src_a = pick(cfg.src_a, acc0_q, acc1_q, data0_q, data1_q);
	assign src_b = pick(cfg.src_b, acc0_q, acc1_q, data0_q, data1_q);

	always_comb begin
		unique case (cfg.op)
			logic_cell_pkg::OP_INC: alu_wide = {1'b0, src_a} + 9'h001;
			logic_cell_pkg::OP_DEC: alu_wide = {1'b0, src_a} - 9'h001;
			logic_cell_pkg::OP_ADD: alu_wide = {1'b0, src_a} + {1'b0, src_b};
			logic_cell_pkg::OP_SUB: alu_wide = {1'b0, src_a} - {1'b0, src_b};
			logic_cell_pkg::OP_AND: alu_wide = {1'b0, src_a & src_b};
			logic_cell_pkg::OP_OR: alu_wide = {1'b0, src_a | src_b};
			logic_cell_pkg::OP_XOR: alu_wide = {1'b0, src_a ^ src_b};
			logic_cell_pkg::OP_PASS: alu_wide = {1'b0, src_a};
		endcase
	end
	assign alu_res = alu_wide[7:0];

	always_comb begin
		unique case (cfg.shift)
			logic_cell_pkg::SH_NONE: shifted = alu_res;
			logic_cell_pkg::SH_LEFT: shifted = {alu_res[6:0], 1'b0};
			logic_cell_pkg::SH_RIGHT: shifted = {1'b0, alu_res[7:1]};
			logic_cell_pkg::SH_SWAP: shifted = {alu_res[3:0], alu_res[7:4]};
		endcase
	end

	// a starved input or a full output queue freezes the whole step
	assign stall = (cfg.pop_in && !q0_out_valid) || (cfg.push_out && !q1_in_ready);
	assign step = dp_run && !stall;
	assign load_byte = q0_out_data;
	assign q1_push_data = cfg.out_from_alu ? shifted : acc0_q;

	assign wr_hit = bus_req.wr;
	assign rd_hit = bus_req.rd;

	// bus writes take priority over a datapath result in the same cycle
	always_ff @(posedge mclk) begin
		if (cell_rst) begin
			acc0_q <= logic_cell_pkg::RESET_BYTE;
			acc1_q <= logic_cell_pkg::RESET_BYTE;
		end else begin
			if (wr_hit && bus_req.addr == logic_cell_pkg::ADDR_ACC_ZERO) begin
				acc0_q <= bus_req.wdata;
			end else if (step && cfg.pop_in && cfg.load_dest == logic_cell_pkg::SRC_ACC0) begin
				acc0_q <= load_byte;
			end else if (step && cfg.wr_acc0) begin
				acc0_q <= shifted;
			end
			if (wr_hit && bus_req.addr == logic_cell_pkg::ADDR_ACC_ONE) begin
				acc1_q <= bus_req.wdata;
			end else if (step && cfg.pop_in && cfg.load_dest == logic_cell_pkg::SRC_ACC1) begin
				acc1_q <= load_byte;
			end else if (step && cfg.wr_acc1) begin
				acc1_q <= shifted;
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (cell_rst) begin
			data0_q <= logic_cell_pkg::RESET_BYTE;
			data1_q <= logic_cell_pkg::RESET_BYTE;
		end else begin
			if (wr_hit && bus_req.addr == logic_cell_pkg::ADDR_DATA_ZERO) begin
				data0_q <= bus_req.wdata;
			end else if (step && cfg.pop_in && cfg.load_dest == logic_cell_pkg::SRC_DATA0) begin
				data0_q <= load_byte;
			end
			if (wr_hit && bus_req.addr == logic_cell_pkg::ADDR_DATA_ONE) begin
				data1_q <= bus_req.wdata;
			end else if (step && cfg.pop_in && cfg.load_dest == logic_cell_pkg::SRC_DATA1) begin
				data1_q <= load_byte;
			end
		end
	end

	// masks, config index and staged low byte survive a soft reset
	always_ff @(posedge mclk) begin
		if (reset) begin
			mask0_q <= logic_cell_pkg::MASK_RESET;
			mask1_q <= logic_cell_pkg::MASK_RESET;
			cfg_index_q <= '0;
			cfg_low_q <= logic_cell_pkg::RESET_BYTE;
			ctrl_q <= logic_cell_pkg::RESET_BYTE;
		end else if (wr_hit) begin
			unique case (bus_req.addr)
				logic_cell_pkg::ADDR_MASK_ZERO: mask0_q <= bus_req.wdata;
				logic_cell_pkg::ADDR_MASK_ONE: mask1_q <= bus_req.wdata;
				logic_cell_pkg::ADDR_CFG_INDEX: cfg_index_q <= bus_req.wdata[2:0];
				logic_cell_pkg::ADDR_CFG_LOW: cfg_low_q <= bus_req.wdata;
				logic_cell_pkg::ADDR_CONTROL: ctrl_q <= bus_req.wdata;
				default: ;
			endcase
		end
	end

	// high byte write commits the whole word, so a step never sees half of one
	always_ff @(posedge mclk) begin
		if (reset) begin
			for (int i = 0; i < logic_cell_pkg::CFG_WORDS; i++) begin
				cfg_mem_q[i] <= logic_cell_pkg::CFG_RESET;
			end
		end else if (wr_hit && bus_req.addr == logic_cell_pkg::ADDR_CFG_HIGH) begin
			cfg_mem_q[cfg_index_q] <= {bus_req.wdata, cfg_low_q};
		end
	end

	byte_queue #(.WIDTH(logic_cell_pkg::DATA_W), .DEPTH(logic_cell_pkg::QUEUE_DEPTH)) u_queue_in (
		.mclk(mclk),
		.reset(cell_rst),
		.in_valid(wr_hit && bus_req.addr == logic_cell_pkg::ADDR_QUEUE_ZERO),
		.in_ready(q0_in_ready),
		.in_data(bus_req.wdata),
		.out_valid(q0_out_valid),
		.out_ready(step && cfg.pop_in),
		.out_data(q0_out_data)
	);

	byte_queue #(.WIDTH(logic_cell_pkg::DATA_W), .DEPTH(logic_cell_pkg::QUEUE_DEPTH)) u_queue_out (
		.mclk(mclk),
		.reset(cell_rst),
		.in_valid(step && cfg.push_out),
		.in_ready(q1_in_ready),
		.in_data(q1_push_data),
		.out_valid(q1_out_valid),
		.out_ready(rd_hit && bus_req.addr == logic_cell_pkg::ADDR_QUEUE_ONE),
		.out_data(q1_out_data)
	);

	// sticky errors clear on status read; a new event in that cycle wins
	always_ff @(posedge mclk) begin
		if (cell_rst) begin
			q0_overflow_q <= 1'b0;
			q1_underflow_q <= 1'b0;
		end else begin
			if (wr_hit && bus_req.addr == logic_cell_pkg::ADDR_QUEUE_ZERO && !q0_in_ready) begin
				q0_overflow_q <= 1'b1;
			end else if (rd_hit && bus_req.addr == logic_cell_pkg::ADDR_STATUS) begin
				q0_overflow_q <= 1'b0;
			end
			if (rd_hit && bus_req.addr == logic_cell_pkg::ADDR_QUEUE_ONE && !q1_out_valid) begin
				q1_underflow_q <= 1'b1;
			end else if (rd_hit && bus_req.addr == logic_cell_pkg::ADDR_STATUS) begin
				q1_underflow_q <= 1'b0;
			end
		end
	end

	assign status_byte = {status_in, q1_out_valid, !q0_in_ready, q1_underflow_q,
		q0_overflow_q};

	always_comb begin
		unique case (bus_req.addr)
			logic_cell_pkg::ADDR_ACC_ZERO: read_mux = acc0_q;
			logic_cell_pkg::ADDR_ACC_ONE: read_mux = acc1_q;
			logic_cell_pkg::ADDR_DATA_ZERO: read_mux = data0_q;
			logic_cell_pkg::ADDR_DATA_ONE: read_mux = data1_q;
			logic_cell_pkg::ADDR_QUEUE_ONE: read_mux = q1_out_valid ? q1_out_data : 8'h00;
			logic_cell_pkg::ADDR_CFG_INDEX: read_mux = {5'h00, cfg_index_q};
			logic_cell_pkg::ADDR_CFG_LOW: read_mux = cfg_mem_q[cfg_index_q][7:0];
			logic_cell_pkg::ADDR_CFG_HIGH: read_mux = cfg_mem_q[cfg_index_q][15:8];
			logic_cell_pkg::ADDR_CONTROL: read_mux = ctrl_q;
			logic_cell_pkg::ADDR_STATUS: read_mux = status_byte;
			logic_cell_pkg::ADDR_MASK_ZERO: read_mux = mask0_q;
			logic_cell_pkg::ADDR_MASK_ONE: read_mux = mask1_q;
			default: read_mux = 8'h00;
		endcase
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			bus_rdata_q <= logic_cell_pkg::RESET_BYTE;
			bus_rvalid_q <= 1'b0;
		end else begin
			bus_rvalid_q <= rd_hit;
			bus_rdata_q <= rd_hit ? read_mux : 8'h00;
		end
	end

	// conditions are registered, one cycle behind the operands
	always_ff @(posedge mclk) begin
		if (cell_rst) begin
			cond_q <= '0;
		end else begin
			cond_q[logic_cell_pkg::COND_EQ0] <= (acc0_q & mask0_q) == (data0_q & mask0_q);
			cond_q[logic_cell_pkg::COND_LT0] <= (acc0_q & mask0_q) < (data0_q & mask0_q);
			cond_q[logic_cell_pkg::COND_EQ1] <= (acc1_q & mask1_q) == (data1_q & mask1_q);
			cond_q[logic_cell_pkg::COND_LT1] <= (acc1_q & mask1_q) < (data1_q & mask1_q);
			cond_q[logic_cell_pkg::COND_ZERO0] <= (acc0_q == 8'h00);
			cond_q[logic_cell_pkg::COND_ZERO1] <= (acc1_q == 8'h00);
			cond_q[logic_cell_pkg::COND_ONES0] <= (acc0_q == 8'hff);
			cond_q[logic_cell_pkg::COND_OVERFLOW] <= step && alu_wide[8];
		end
	end

	default clocking cb @(posedge mclk); endclocking
	default disable iff (reset);

	sequence s_write_acc0;
		wr_hit && bus_req.addr == logic_cell_pkg::ADDR_ACC_ZERO && !cell_rst;
	endsequence
	sequence s_read_empty_q1;
		rd_hit && bus_req.addr == logic_cell_pkg::ADDR_QUEUE_ONE && !q1_out_valid && !cell_rst;
	endsequence
	sequence s_add_into_acc0;
		step && !cell_rst && cfg.op == logic_cell_pkg::OP_ADD && cfg.wr_acc0 && !cfg.pop_in
			&& cfg.shift == logic_cell_pkg::SH_NONE && !(wr_hit && bus_req.addr == '0);
	endsequence

	a_acc_bus_write: assert property (s_write_acc0 |=> acc0_q == $past(bus_req.wdata))
		else $error("bus write to accumulator zero lost");
	a_bus_read_answer: assert property (rd_hit |=> bus_rvalid_q ##1 !bus_rvalid_q || $past(rd_hit))
		else $error("read answer not a single cycle after request");
	a_alu_add_single: assert property (s_add_into_acc0 |=>
		acc0_q == 8'($past(src_a) + $past(src_b)))
		else $error("add result not in accumulator zero next cycle");
	a_empty_read_zero: assert property (s_read_empty_q1 |=>
		bus_rdata_q == 8'h00 && q1_underflow_q)
		else $error("empty queue read did not answer zero and flag");
	a_full_write_flag: assert property (wr_hit && bus_req.addr == logic_cell_pkg::ADDR_QUEUE_ZERO
		&& !q0_in_ready && !cell_rst |=> q0_overflow_q [*2] or (q0_overflow_q ##1 1'b1))
		else $error("write to full queue not flagged");
	a_stall_freezes: assert property (dp_run && stall && !wr_hit && !cell_rst |=>
		$stable(acc0_q) && $stable(acc1_q))
		else $error("accumulators moved during a stall");
	a_compare_equal: assert property (!cell_rst |=> cond_q[logic_cell_pkg::COND_EQ0] ==
		(($past(acc0_q) & $past(mask0_q)) == ($past(data0_q) & $past(mask0_q))))
		else $error("masked equal compare wrong");
	a_cell_reset_clear: assert property (cell_rst |=> acc0_q == 8'h00 && data1_q == 8'h00
		&& cond_q == '0)
		else $error("working registers not cleared in cell reset");
	a_control_write: assert property (wr_hit && bus_req.addr == logic_cell_pkg::ADDR_CONTROL
		|=> ctrl_q == $past(bus_req.wdata))
		else $error("control register write lost");
endmodule

// ---- inc/logic_cell_pkg.sv ----
// constants, field layouts and carriers for one configurable logic cell
// assumes a single 20 MHz clock and an 8-bit system bus with byte-wide registers
package logic_cell_pkg;
	localparam int unsigned DATA_W = 8;
	localparam int unsigned ADDR_W = 4;
	localparam int unsigned PLD_COUNT = 2;
	localparam int unsigned PLD_IN = 12;
	localparam int unsigned PLD_TERMS = 8;
	localparam int unsigned PLD_OUTS = 4;
	localparam int unsigned QUEUE_DEPTH = 4;
	localparam int unsigned CFG_WORDS = 8;
	localparam int unsigned CFG_W = 16;
	localparam int unsigned CFG_IDX_W = 3;
	localparam int unsigned COND_W = 8;
	localparam int unsigned CTRL_OUT_W = 4;
	localparam int unsigned STATUS_IN_W = 4;

	// register byte addresses on the system bus
	localparam logic [3:0] ADDR_ACC_ZERO = 4'h0;
	localparam logic [3:0] ADDR_ACC_ONE = 4'h1;
	localparam logic [3:0] ADDR_DATA_ZERO = 4'h2;
	localparam logic [3:0] ADDR_DATA_ONE = 4'h3;
	localparam logic [3:0] ADDR_QUEUE_ZERO = 4'h4;
	localparam logic [3:0] ADDR_QUEUE_ONE = 4'h5;
	localparam logic [3:0] ADDR_CFG_INDEX = 4'h6;
	localparam logic [3:0] ADDR_CFG_LOW = 4'h7;
	localparam logic [3:0] ADDR_CFG_HIGH = 4'h8;
	localparam logic [3:0] ADDR_CONTROL = 4'h9;
	localparam logic [3:0] ADDR_STATUS = 4'ha;
	localparam logic [3:0] ADDR_MASK_ZERO = 4'hb;
	localparam logic [3:0] ADDR_MASK_ONE = 4'hc;

	localparam logic [7:0] RESET_BYTE = 8'h00;
	localparam logic [7:0] MASK_RESET = 8'hff;
	localparam logic [15:0] CFG_RESET = 16'h0000;

	// control register bits
	localparam int unsigned CTRL_DP_RUN = 0;
	localparam int unsigned CTRL_SOFT_RESET = 1;
	localparam int unsigned CTRL_PLD_RUN = 2;
	localparam int unsigned CTRL_OUT_LSB = 4;

	// status register bits
	localparam int unsigned STAT_Q0_OVERFLOW = 0;
	localparam int unsigned STAT_Q1_UNDERFLOW = 1;
	localparam int unsigned STAT_Q0_FULL = 2;
	localparam int unsigned STAT_Q1_NONEMPTY = 3;
	localparam int unsigned STAT_IN_LSB = 4;

	// condition output bits
	localparam int unsigned COND_EQ0 = 0;
	localparam int unsigned COND_LT0 = 1;
	localparam int unsigned COND_EQ1 = 2;
	localparam int unsigned COND_LT1 = 3;
	localparam int unsigned COND_ZERO0 = 4;
	localparam int unsigned COND_ZERO1 = 5;
	localparam int unsigned COND_ONES0 = 6;
	localparam int unsigned COND_OVERFLOW = 7;

	typedef enum logic [2:0] {
		OP_INC, OP_DEC, OP_ADD, OP_SUB, OP_AND, OP_OR, OP_XOR, OP_PASS
	} alu_op_e;

	typedef enum logic [1:0] {SRC_ACC0, SRC_ACC1, SRC_DATA0, SRC_DATA1} src_sel_e;
	typedef enum logic [1:0] {SH_NONE, SH_LEFT, SH_RIGHT, SH_SWAP} shift_e;

	// one datapath configuration word, msb first
	typedef struct packed {
		logic out_from_alu;
		logic push_out;
		src_sel_e load_dest;
		logic pop_in;
		shift_e shift;
		logic wr_acc1;
		logic wr_acc0;
		src_sel_e src_b;
		src_sel_e src_a;
		alu_op_e op;
	} dp_cfg_s;

	typedef struct packed {
		logic [PLD_IN-1:0] use_in;
		logic [PLD_IN-1:0] invert;
	} term_cfg_s;

	typedef struct packed {
		term_cfg_s [PLD_TERMS-1:0] term;
		logic [PLD_OUTS-1:0][PLD_TERMS-1:0] or_sel;
		logic [PLD_OUTS-1:0] reg_sel;
	} pld_cfg_s;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic wr;
		logic rd;
		logic [DATA_W-1:0] wdata;
	} bus_req_s;
endpackage

// ---- tb/bus_side_model.sv ----
// bus master stand-in for the cell's register bus
// assumes rising-edge sampling; drives 1 ns after the edge
`timescale 1ns/10ps
module bus_side_model (
	input wire logic mclk,
	input wire logic [7:0] rdata,
	input wire logic rvalid,
	output logic_cell_pkg::bus_req_s req
);
	initial begin
		req = '0;
	end
	// wr stays high so writes can run back to back; idle ends it
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		req = '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
		@(posedge mclk);
		#1;
	endtask
	// released data lines carry the inverse of the last byte
	task automatic idle();
		req = '{addr: req.addr, wr: 1'b0, rd: 1'b0, wdata: ~req.wdata};
		@(posedge mclk);
		#1;
	endtask
	task automatic rd(input logic [3:0] a, output logic [7:0] d, output logic v);
		req = '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
		@(posedge mclk);
		#1;
		req = '0;
		d = rdata;
		v = rvalid;
		@(posedge mclk);
		#1;
	endtask
endmodule

// ---- tb/tb_configurable_logic_cell.sv ----
// self-checking bench for the configurable logic cell
// assumes the bus model above and cfg_sel held at word 0
`timescale 1ns/10ps
module tb_configurable_logic_cell;
	logic mclk = 1'b0;
	logic reset = 1'b1;
	logic [7:0] rdata;
	logic rvalid;
	logic_cell_pkg::bus_req_s req;
	logic [1:0][11:0] pin = '0;
	logic_cell_pkg::pld_cfg_s [1:0] pcfg = '0;
	logic [1:0][3:0] pout;
	logic [7:0] cond;
	logic [7:0] ctrl;
	logic [3:0] st_in = 4'ha;
	int num_errors = 0;
	int check_count = 0;
	int cycles = 0;
	always #25 mclk = ~mclk;
	bus_side_model u_bus (.mclk(mclk), .rdata(rdata), .rvalid(rvalid), .req(req));
	configurable_logic_cell u_dut (.mclk(mclk), .reset(reset), .bus_req(req),
		.bus_rdata_q(rdata), .bus_rvalid_q(rvalid), .pld_in(pin), .pld_cfg(pcfg),
		.pld_out(pout), .cfg_sel(3'h0), .cond_q(cond), .status_in(st_in), .ctrl_q(ctrl));
	task automatic results();
		$display("errors %0d checks %0d", num_errors, check_count);
		if (num_errors == 0 && check_count > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		check_count++;
		if (seen !== exp) begin
			num_errors++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic rdchk(input logic [3:0] a, input logic [7:0] exp);
		logic [7:0] d;
		logic v;
		u_bus.rd(a, d, v);
		check({7'h00, v}, 8'h01);
		check(d, exp);
	endtask
	// one datapath step: run bit set for exactly one edge
	task automatic step();
		u_bus.wr(4'h9, 8'h01);
		u_bus.wr(4'h9, 8'h00);
		u_bus.idle();
	endtask
	task automatic cw(input logic [15:0] w);
		u_bus.wr(4'h6, 8'h00);
		u_bus.wr(4'h7, w[7:0]);
		u_bus.wr(4'h8, w[15:8]);
		u_bus.idle();
	endtask
	function automatic logic [7:0] alu_ref(input int op, input logic [7:0] a, input logic [7:0] b);
		case (op)
			0: return a + 8'h01;
			1: return a - 8'h01;
			2: return a + b;
			3: return a - b;
			4: return a & b;
			5: return a | b;
			6: return a ^ b;
			default: return a;
		endcase
	endfunction
	task automatic t_reset();
		for (int i = 0; i < 4; i++) begin
			rdchk(i[3:0], 8'h00);
		end
		rdchk(4'hb, 8'hff);
		rdchk(4'h9, 8'h00);
		rdchk(4'hf, 8'h00);
		$display("test reset done");
	endtask
	task automatic t_regs();
		for (int i = 0; i < 4; i++) begin
			u_bus.wr(i[3:0], 8'h5a ^ i[7:0]);
		end
		u_bus.idle();
		for (int i = 0; i < 4; i++) begin
			rdchk(i[3:0], 8'h5a ^ i[7:0]);
		end
		$display("test regs done");
	endtask
	task automatic t_alu();
		for (int op = 0; op < 8; op++) begin
			u_bus.wr(4'h0, 8'h96);
			u_bus.wr(4'h2, 8'h3c);
			cw({8'h00, 8'hc0 | op[7:0]});
			step();
			rdchk(4'h0, alu_ref(op, 8'h96, 8'h3c));
		end
		$display("test alu done");
	endtask
	task automatic t_queue();
		for (int i = 0; i < 5; i++) begin
			u_bus.wr(4'h4, 8'h10 + i[7:0]);
		end
		u_bus.idle();
		rdchk(4'ha, 8'ha5);
		rdchk(4'ha, 8'ha4);
		cw(16'h1807);
		for (int i = 0; i < 5; i++) begin
			step();
			rdchk(4'h1, 8'h10 + ((i < 4) ? i[7:0] : 8'h03));
		end
		$display("test queue zero done");
	endtask
	task automatic t_out();
		rdchk(4'h5, 8'h00);
		rdchk(4'ha, 8'ha2);
		u_bus.wr(4'h0, 8'h77);
		cw(16'h4007);
		step();
		cw(16'hc000);
		step();
		rdchk(4'ha, 8'ha8);
		rdchk(4'h5, 8'h77);
		rdchk(4'h5, 8'h78);
		$display("test queue one done");
	endtask
	task automatic t_soft();
		u_bus.wr(4'h0, 8'h09);
		u_bus.wr(4'h9, 8'h52);
		u_bus.wr(4'h9, 8'h50);
		u_bus.idle();
		check(ctrl, 8'h50);
		rdchk(4'h0, 8'h00);
		cw(16'h0000);
		u_bus.wr(4'h9, 8'h01);
		u_bus.wr(4'h0, 8'h00);
		repeat (3) u_bus.idle();
		check({7'h00, cond[4]}, 8'h01);
		check(cond, 8'h35);
		u_bus.wr(4'h0, 8'hff);
		repeat (3) u_bus.idle();
		check({6'h00, cond[6], cond[4]}, 8'h02);
		check(cond, 8'he4);
		u_bus.wr(4'h9, 8'h00);
		u_bus.idle();
		$display("test control done");
	endtask
	task automatic t_pld();
		logic [3:0] exp [4] = '{4'h5, 4'h7, 4'h4, 4'h0};
		logic [11:0] drv [3] = '{12'h003, 12'h001, 12'h000};
		for (int i = 0; i < 2; i++) begin
			pcfg[i].term[0].use_in = 12'h001;
			pcfg[i].term[1].use_in = 12'h003;
			pcfg[i].term[1].invert = 12'h002;
			pcfg[i].or_sel[0] = 8'h01;
			pcfg[i].or_sel[1] = 8'h02;
			pcfg[i].or_sel[2] = 8'h01;
			pcfg[i].reg_sel = 4'h4;
		end
		u_bus.wr(4'h9, 8'h04);
		u_bus.idle();
		for (int k = 0; k < 4; k++) begin
			if (k < 3) pin = {drv[k], drv[k]};
			if (k == 2) #1;
			else begin
				@(posedge mclk);
				#1;
			end
			for (int i = 0; i < 2; i++) begin
				check({4'h0, pout[i]}, {4'h0, exp[k]});
			end
		end
		$display("test arrays done");
	endtask
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 6000) begin
			num_errors++;
			results();
		end
	end
	initial begin
		repeat (5) @(posedge mclk);
		#1;
		reset = 1'b0;
		t_reset();
		t_regs();
		t_alu();
		t_queue();
		t_out();
		t_soft();
		t_pld();
		results();
	end
endmodule
